/* verilog/power_mode_and_lp_osc_calibration.sv */
// Power mode control, core clock divider and low power oscillator calibration.
//
// What this block does
// - Divider code 0..7 divides the PLL rate by 1 up to 128.
// - Clearing bit 3 powers down the core; reset and wake set it.
// - Bit 4 clears only with bit 3 in the same write; wake sets it.
// - Bit 5 clears only with bits 3, 4 and 5; reset and wake set it.
// - LIN wake detection stays alive; wake timer may run on LP osc.
// - Peripheral power-down covers SRAM, flash, GPIO, SPI and UART.
// - PLL power-down stops PLL-clocked timers; the wake timer then runs only on LP osc.
// - Bit 6 enables the crystal circuitry when set.
// - Bit 7 with the high voltage enable powers precision input.
// - A 9-bit reference counter runs on precision osc or crystal.
// - A 10-bit counter runs on LP osc, direct or divided by four.
// - Low trim nibble is user trim; larger value lowers frequency.
// - Reference reaching 0x1FF stops and holds both counters.
// - Control bit 4 picks crystal when set, precision when clear.
// - Control bit 3 resets both counters and disables calibration.
// - Control bit 2 clears LP counter, bit 1 clears reference.
// - Control bit 0 starts a run; clearing it aborts the run.
// - A run lasts 511 reference ticks, about 4 ms or 16 ms.
// - Status gives two-bit state and an in-progress flag.
//
// Register access over Wishbone was decided locally.
`include "pmc_map.svh"

module power_mode_and_lp_osc_calibration
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Clock ticks, one cycle each, and wake sources.
  input wire logic pll_tick,
  input wire logic precision_osc_tick,
  input wire logic crystal_tick,
  input wire logic lp_osc_tick,
  input wire logic wake_event,
  input wire logic precision_osc_hv_enable,
  input wire logic wakeup_timer_on_lp_osc,
  // Power and clock controls.
  output logic core_clock_enable,
  output logic core_power_on,
  output logic periph_power_on,
  output logic pll_power_on,
  output logic xtal_power_on,
  output logic precision_input_on,
  output logic lin_wake_detect_on,
  output logic wakeup_timer_run,
  output logic pll_timer_run,
  output logic [3:0] lp_osc_trim
);

  // ****************************************************
  // State
  // ****************************************************

  // All registered state of the block.
  typedef struct packed
  {
    logic [7:0] power;
    logic [3:0] trim;
    logic [4:0] control;
    pmc_pkg::cal_state_t state;
    logic busy;
    logic [8:0] ref_count;
    logic [9:0] lp_count;
    logic [1:0] lp_prescale;
    logic [6:0] div_count;
    logic core_en;
    logic ack;
    logic [31:0] rdata;
    logic prec_on;
    logic wake_timer;
    logic pll_timer;
    logic lin_wake;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ****************************************************
  // Bus decode
  // ****************************************************

  logic access;
  logic write;
  logic [2:0] divider;
  logic [6:0] div_mask;
  logic ref_tick;
  logic lp_tick;
  logic start;
  pmc_pkg::cal_status_t status_code;

  // A request is served once; ack drops the cycle after it rises.
  assign access = cyc_i && stb_i && !cur.ack;
  assign write = access && we_i && sel_i[0];
  assign divider = cur.power[`PMC_POW_DIV_LSB +: 3];

  // Low divider bits; all ones marks the last PLL tick of a period.
  // power of two
  assign div_mask = 7'((8'h01 << divider) - 8'h01);

  assign ref_tick = cur.control[`PMC_CAL_SOURCE] ? crystal_tick
                                                 : precision_osc_tick;

  assign lp_tick = lp_osc_tick && (!cur.control[`PMC_CAL_SOURCE] ||
                   cur.lp_prescale == `PMC_LP_PRESCALE_LAST);

  assign start = write && adr_i == `PMC_ADDR_CAL_CONTROL &&
                 dat_i[`PMC_CAL_ENABLE];

  // Maps the sequencer state onto the code software reads.
  always_comb
  begin
    unique case (cur.state)
      pmc_pkg::CAL_IDLE: status_code = pmc_pkg::STAT_IDLE;
      pmc_pkg::CAL_ENABLE: status_code = pmc_pkg::STAT_ENABLE;
      pmc_pkg::CAL_COUNT: status_code = pmc_pkg::STAT_COUNT;
      pmc_pkg::CAL_FINISH: status_code = pmc_pkg::STAT_FINISH;
    endcase
  end

  // ****************************************************
  // Next state
  // ****************************************************

  // Computes every next value of the block in one pass.
  always_comb
  begin
    next_cur = cur;
    next_cur.ack = access;
    next_cur.rdata = 32'h00000000;

    // Read data; unmapped addresses answer with zero.
    if (access && !we_i)
    begin
      unique case (adr_i)
        `PMC_ADDR_POWER_MODE: next_cur.rdata = {24'h000000, cur.power};
        `PMC_ADDR_LP_TRIM: next_cur.rdata = {28'h0000000, cur.trim};
        `PMC_ADDR_CAL_CONTROL:
          next_cur.rdata = {27'h0000000, cur.control};
        `PMC_ADDR_CAL_STATUS:
          next_cur.rdata = {28'h0000000, status_code,
                            cur.control[`PMC_CAL_ENABLE], cur.busy};
        `PMC_ADDR_REF_COUNT: next_cur.rdata = {23'h000000, cur.ref_count};
        `PMC_ADDR_LP_COUNT: next_cur.rdata = {22'h000000, cur.lp_count};
        default: next_cur.rdata = 32'h00000000;
      endcase
    end

    // Power mode write, with the power-down ordering enforced.
    if (write && adr_i == `PMC_ADDR_POWER_MODE)
    begin
      next_cur.power = dat_i[7:0];
      next_cur.power[`PMC_POW_PERIPH] = dat_i[`PMC_POW_PERIPH] ||
                                        dat_i[`PMC_POW_CORE];
      next_cur.power[`PMC_POW_PLL] = dat_i[`PMC_POW_PLL] ||
                                     dat_i[`PMC_POW_PERIPH] ||
                                     dat_i[`PMC_POW_CORE];
    end

    // A wake event wins over a write in the same cycle.
    if (wake_event)
    begin
      next_cur.power[`PMC_POW_CORE] = 1'b1;
      next_cur.power[`PMC_POW_PERIPH] = 1'b1;
      next_cur.power[`PMC_POW_PLL] = 1'b1;
    end

    if (write && adr_i == `PMC_ADDR_LP_TRIM)
    begin
      next_cur.trim = dat_i[3:0];
    end

    // Calibration control write; reserved bits are dropped.
    if (write && adr_i == `PMC_ADDR_CAL_CONTROL)
    begin
      next_cur.control = dat_i[4:0];
    end

    // Core clock divider runs only while core and PLL are powered.
    next_cur.core_en = 1'b0;
    if (!cur.power[`PMC_POW_CORE] || !cur.power[`PMC_POW_PLL])
    begin
      next_cur.div_count = 7'h00;
    end
    else if (pll_tick)
    begin
      if ((cur.div_count & div_mask) == div_mask)
      begin
        next_cur.core_en = 1'b1;
        next_cur.div_count = 7'h00;
      end
      else
      begin
        next_cur.div_count = 7'(cur.div_count + 7'h01);
      end
    end

    // Free running; a run restarts it so every run starts in one phase.
    // Divide-by-four stage for the LP oscillator ticks.
    if (lp_osc_tick)
    begin
      next_cur.lp_prescale = 2'(cur.lp_prescale + 2'h1);
    end

    // Calibration sequencer.
    unique case (cur.state)
      pmc_pkg::CAL_IDLE:
      begin
        if (start)
        begin
          next_cur.state = pmc_pkg::CAL_ENABLE;
          next_cur.busy = 1'b1;
        end
      end
      pmc_pkg::CAL_ENABLE:
      begin
        // Fresh counts for every run.
        next_cur.ref_count = 9'h000;
        next_cur.lp_count = 10'h000;
        next_cur.lp_prescale = 2'h0;
        next_cur.state = pmc_pkg::CAL_COUNT;
      end
      pmc_pkg::CAL_COUNT:
      begin
        if (ref_tick)
        begin
          next_cur.ref_count = 9'(cur.ref_count + 9'h001);
        end
        if (lp_tick && cur.lp_count != `PMC_LP_FULL)
        begin
          next_cur.lp_count = 10'(cur.lp_count + 10'h001);
        end
        if (ref_tick && cur.ref_count == 9'(`PMC_REF_FULL - 9'h001))
        begin
          next_cur.state = pmc_pkg::CAL_FINISH;
        end
      end
      pmc_pkg::CAL_FINISH:
      begin
        next_cur.busy = 1'b0;
        next_cur.state = pmc_pkg::CAL_IDLE;
      end
    endcase

    // An abort leaves the counts where they stopped, for software to read.
    // abort on clear
    if (!cur.control[`PMC_CAL_ENABLE] && cur.state != pmc_pkg::CAL_IDLE &&
        cur.state != pmc_pkg::CAL_FINISH)
    begin
      next_cur.state = pmc_pkg::CAL_IDLE;
      next_cur.busy = 1'b0;
    end

    if (cur.control[`PMC_CAL_CLR_LP])
    begin
      next_cur.lp_count = 10'h000;
    end
    if (cur.control[`PMC_CAL_CLR_REF])
    begin
      next_cur.ref_count = 9'h000;
    end

    // A start written in the same cycle wins over the stale reset level.
    // calibration reset
    if (cur.control[`PMC_CAL_RESET] && !start)
    begin
      next_cur.ref_count = 9'h000;
      next_cur.lp_count = 10'h000;
      next_cur.state = pmc_pkg::CAL_IDLE;
      next_cur.busy = 1'b0;
    end

    next_cur.prec_on = next_cur.power[`PMC_POW_PREC] &&
                       precision_osc_hv_enable;

    next_cur.wake_timer = next_cur.power[`PMC_POW_PERIPH] ||
                          wakeup_timer_on_lp_osc;

    next_cur.pll_timer = next_cur.power[`PMC_POW_PLL];

    next_cur.lin_wake = 1'b1;
  end

  // ****************************************************
  // Registers
  // ****************************************************

  // Registers the whole state; reset loads documented defaults.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cur.power <= `PMC_POW_RESET;
      cur.trim <= `PMC_TRIM_RESET;
      cur.control <= `PMC_CAL_CTL_RESET;
      cur.state <= pmc_pkg::CAL_IDLE;
      cur.busy <= 1'b0;
      cur.ref_count <= 9'h000;
      cur.lp_count <= 10'h000;
      cur.lp_prescale <= 2'h0;
      cur.div_count <= 7'h00;
      cur.core_en <= 1'b0;
      cur.ack <= 1'b0;
      cur.rdata <= 32'h00000000;
      cur.prec_on <= 1'b0;
      cur.wake_timer <= 1'b1;
      cur.pll_timer <= 1'b1;
      cur.lin_wake <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************

  // Every output is a field of the registered state.
  assign dat_o = cur.rdata;
  assign ack_o = cur.ack;
  assign core_clock_enable = cur.core_en;
  assign core_power_on = cur.power[`PMC_POW_CORE];
  assign periph_power_on = cur.power[`PMC_POW_PERIPH];
  assign pll_power_on = cur.power[`PMC_POW_PLL];
  assign xtal_power_on = cur.power[`PMC_POW_XTAL];
  assign precision_input_on = cur.prec_on;
  assign lin_wake_detect_on = cur.lin_wake;
  assign wakeup_timer_run = cur.wake_timer;
  assign pll_timer_run = cur.pll_timer;
  assign lp_osc_trim = cur.trim;

endmodule : power_mode_and_lp_osc_calibration

/* common/pmc_map.svh */
// Register offsets, field positions, reset values and counts of the block.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ****************************************************
// Register byte addresses
// ****************************************************
`define PMC_ADDR_POWER_MODE 32'hFFFF0408
`define PMC_ADDR_LP_TRIM 32'hFFFF042C
`define PMC_ADDR_CAL_CONTROL 32'hFFFF0440
`define PMC_ADDR_CAL_STATUS 32'hFFFF0444
`define PMC_ADDR_REF_COUNT 32'hFFFF0448
`define PMC_ADDR_LP_COUNT 32'hFFFF044C

// ****************************************************
// Power mode control fields and reset
// ****************************************************
`define PMC_POW_DIV_LSB 0
`define PMC_POW_CORE 3
`define PMC_POW_PERIPH 4
`define PMC_POW_PLL 5
`define PMC_POW_XTAL 6
`define PMC_POW_PREC 7
`define PMC_POW_RESET 8'h79

// ****************************************************
// Trim and calibration control fields and reset
// ****************************************************
`define PMC_TRIM_RESET 4'h8
`define PMC_CAL_ENABLE 0
`define PMC_CAL_CLR_REF 1
`define PMC_CAL_CLR_LP 2
`define PMC_CAL_RESET 3
`define PMC_CAL_SOURCE 4
`define PMC_CAL_CTL_RESET 5'h00

// ****************************************************
// Calibration counts
// ****************************************************
`define PMC_REF_FULL 9'h1FF
`define PMC_LP_FULL 10'h3FF
`define PMC_LP_PRESCALE_LAST 2'h3

`endif

/* common/pmc_pkg.sv */
// Types shared by the power mode and calibration block.
package pmc_pkg;

  // Calibration sequencer states, Gray coded along the run.
  typedef enum logic [1:0]
  {
    CAL_IDLE = 2'h0,
    CAL_ENABLE = 2'h1,
    CAL_COUNT = 2'h3,
    CAL_FINISH = 2'h2
  } cal_state_t;

  // Status codes reported to software.
  typedef enum logic [1:0]
  {
    STAT_IDLE = 2'h0,
    STAT_ENABLE = 2'h1,
    STAT_COUNT = 2'h2,
    STAT_FINISH = 2'h3
  } cal_status_t;

endpackage : pmc_pkg

/* tb/pmc_checker_asserts.sv */
// Concurrent checks on the ports of the power mode and calibration block.
`include "pmc_map.svh"

module pmc_checker
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register bus.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic ack_o,
  // Ticks and wake sources.
  input wire logic pll_tick,
  input wire logic wake_event,
  input wire logic precision_osc_hv_enable,
  input wire logic wakeup_timer_on_lp_osc,
  // Power and clock controls.
  input wire logic core_clock_enable,
  input wire logic core_power_on,
  input wire logic periph_power_on,
  input wire logic pll_power_on,
  input wire logic precision_input_on,
  input wire logic lin_wake_detect_on,
  input wire logic wakeup_timer_run,
  input wire logic pll_timer_run,
  input wire logic [3:0] lp_osc_trim
);
  // ****************************************
  // Port relations
  // ****************************************
  // All checks share the one clock and reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Every request is answered by a single-cycle acknowledge.
  ack_after_req_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged");
  ack_one_cycle_a: assert property (ack_o |=> !ack_o)
    else $error("acknowledge held too long");
  wake_powers_up_a: assert property (wake_event |-> ##[1:2]
    (core_power_on && periph_power_on && pll_power_on))
    else $error("wake did not restore power");
  periph_with_core_a: assert property (
    core_power_on |-> periph_power_on)
    else $error("peripherals off with core on");
  pll_kept_on_a: assert property ((core_power_on || periph_power_on)
    |-> pll_power_on)
    else $error("pll off while core or peripherals on");
  lin_wake_alive_a: assert property (lin_wake_detect_on)
    else $error("lin wake detection off");
  lp_timer_runs_a: assert property (wakeup_timer_on_lp_osc |=>
    wakeup_timer_run)
    else $error("wake timer stopped on lp clock");
  pll_timer_follow_a: assert property (
    pll_timer_run == pll_power_on)
    else $error("pll timer does not follow pll power");
  precision_gated_a: assert property (!precision_osc_hv_enable |=>
    !precision_input_on)
    else $error("precision input on without enable");
  divider_on_tick_a: assert property (core_clock_enable |->
    $past(pll_tick))
    else $error("core enable without pll tick");
  trim_by_write_a: assert property ($changed(lp_osc_trim) |->
    ack_o && we_i && adr_i == `PMC_ADDR_LP_TRIM)
    else $error("trim changed without a write");
endmodule : pmc_checker

bind power_mode_and_lp_osc_calibration pmc_checker chk
(
  .clk(clk),
  .reset(reset),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .ack_o(ack_o),
  .pll_tick(pll_tick),
  .wake_event(wake_event),
  .precision_osc_hv_enable(precision_osc_hv_enable),
  .wakeup_timer_on_lp_osc(wakeup_timer_on_lp_osc),
  .core_clock_enable(core_clock_enable),
  .core_power_on(core_power_on),
  .periph_power_on(periph_power_on),
  .pll_power_on(pll_power_on),
  .precision_input_on(precision_input_on),
  .lin_wake_detect_on(lin_wake_detect_on),
  .wakeup_timer_run(wakeup_timer_run),
  .pll_timer_run(pll_timer_run),
  .lp_osc_trim(lp_osc_trim)
);

/* tb/power_mode_and_lp_osc_calibration_tb.sv */
// Register level testbench of the power mode and calibration block.
`include "pmc_map.svh"

module power_mode_and_lp_osc_calibration_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, cyc_i, stb_i, we_i, ack_o;
  logic [31:0] adr_i, dat_i, dat_o, rdat, r1;
  logic [3:0] sel_i, lp_osc_trim;
  logic pll_tick, precision_osc_tick, crystal_tick, lp_osc_tick;
  logic wake_event, precision_osc_hv_enable, wakeup_timer_on_lp_osc;
  logic core_clock_enable, core_power_on, periph_power_on, pll_power_on;
  logic xtal_power_on, precision_input_on, lin_wake_detect_on;
  logic wakeup_timer_run, pll_timer_run;
  logic [7:0] wv [5] = '{8'h48, 8'h50, 8'h71, 8'h61, 8'h01};
  logic [7:0] ev [5] = '{8'h78, 8'h70, 8'h71, 8'h61, 8'h01};
  int bad_count, comparisons, cnt;
  localparam logic [31:0] POW = `PMC_ADDR_POWER_MODE;
  localparam logic [31:0] TRM = `PMC_ADDR_LP_TRIM;
  localparam logic [31:0] CTL = `PMC_ADDR_CAL_CONTROL;
  localparam logic [31:0] STA = `PMC_ADDR_CAL_STATUS;
  localparam logic [31:0] REF = `PMC_ADDR_REF_COUNT;
  localparam logic [31:0] LPC = `PMC_ADDR_LP_COUNT;

  power_mode_and_lp_osc_calibration dut
  (
    .clk(clk),
    .reset(reset),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .pll_tick(pll_tick),
    .precision_osc_tick(precision_osc_tick),
    .crystal_tick(crystal_tick),
    .lp_osc_tick(lp_osc_tick),
    .wake_event(wake_event),
    .precision_osc_hv_enable(precision_osc_hv_enable),
    .wakeup_timer_on_lp_osc(wakeup_timer_on_lp_osc),
    .core_clock_enable(core_clock_enable),
    .core_power_on(core_power_on),
    .periph_power_on(periph_power_on),
    .pll_power_on(pll_power_on),
    .xtal_power_on(xtal_power_on),
    .precision_input_on(precision_input_on),
    .lin_wake_detect_on(lin_wake_detect_on),
    .wakeup_timer_run(wakeup_timer_run),
    .pll_timer_run(pll_timer_run),
    .lp_osc_trim(lp_osc_trim)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  // Prints the verdict and ends the run.
  task final_report;
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Compares a seen value against the expected one.
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // One classic bus cycle, held until acknowledge is sampled.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    // Waits as long as it takes; only the watchdog ends a hang.
    @(posedge clk);
    while (ack_o !== 1'b1)
    begin
      @(posedge clk);
    end
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus

  // Full-word write.
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  // Read with comparison.
  task rd(input string n, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    check(n, rdat, e);
  endtask : rd

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    final_report();
  end

  // Main sequence of register accesses.
  initial
  begin
    {reset, pll_tick, precision_osc_tick, crystal_tick} = 4'hF;
    {lp_osc_tick, precision_osc_hv_enable} = 2'h3;
    {cyc_i, stb_i, we_i, wake_event, wakeup_timer_on_lp_osc} = 5'h00;
    {adr_i, dat_i, sel_i} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd("power reset", POW, 32'h79);
    rd("trim reset", TRM, 32'h8);
    rd("control reset", CTL, 32'h0);
    rd("unmapped", 32'hFFFF0450, 32'h0);
    wr(TRM, 32'hF5);
    bus(1'b1, TRM, 32'h3, 4'h0);
    rd("trim", TRM, 32'h5);
    check("trim pins", lp_osc_trim, 4'h5);
    for (int i = 0; i < 5; i++)
    begin
      wr(POW, wv[i]);
      rd("power", POW, ev[i]);
      check("power pins", {pll_power_on, periph_power_on, core_power_on},
        ev[i][5:3]);
    end
    check("pll timer", pll_timer_run, 1'b0);
    check("wake timer", wakeup_timer_run, 1'b0);
    check("lin wake", lin_wake_detect_on, 1'b1);
    wakeup_timer_on_lp_osc <= 1'b1;
    repeat (2) @(posedge clk);
    check("wake timer lp", wakeup_timer_run, 1'b1);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    rd("after wake", POW, 32'h39);
    wr(POW, 32'hB9);
    rd("precision", POW, 32'hB9);
    check("xtal off", {xtal_power_on, precision_input_on}, 2'h1);
    precision_osc_hv_enable <= 1'b0;
    rd("precision", POW, 32'hB9);
    check("hv gate", precision_input_on, 1'b0);
    for (int d = 0; d < 8; d++)
    begin
      wr(POW, 32'h78 | d);
      repeat (256) @(posedge clk);
      cnt = 0;
      repeat (256)
      begin
        @(posedge clk);
        cnt += core_clock_enable;
      end
      check("divider", cnt, 256 >> d);
    end
    // Precision osc reference, lp osc counted undivided
    wr(CTL, 32'h1);
    rd("status run", STA, 32'hB);
    repeat (600) @(posedge clk);
    bus(1'b0, STA, 32'h0, 4'hF);
    check("status done", rdat & 32'hD, 32'h0);
    rd("ref full", REF, 32'h1FF);
    rd("lp count", LPC, 32'h1FF);
    repeat (50) @(posedge clk);
    rd("ref held", REF, 32'h1FF);
    wr(CTL, 32'h2);
    rd("ref clear", REF, 32'h0);
    rd("lp kept", LPC, 32'h1FF);
    wr(CTL, 32'h4);
    rd("lp clear", LPC, 32'h0);
    precision_osc_tick <= 1'b0;
    wr(CTL, 32'h10);
    wr(CTL, 32'h11);
    repeat (600) @(posedge clk);
    rd("crystal ref", REF, 32'h1FF);
    bus(1'b0, LPC, 32'h0, 4'hF);
    check("lp quarter", rdat >= 127 && rdat <= 128, 1'b1);
    // slow lp count steps trim down
    wr(TRM, 32'h4);
    check("trim step", lp_osc_trim, 4'h4);
    precision_osc_tick <= 1'b1;
    wr(CTL, 32'h8);
    rd("cal reset", REF, 32'h0);
    rd("cal reset lp", LPC, 32'h0);
    wr(CTL, 32'h0);
    wr(CTL, 32'h1);
    wr(CTL, 32'h0);
    bus(1'b0, REF, 32'h0, 4'hF);
    r1 = rdat;
    check("abort early", r1 < 32'h1FF, 1'b1);
    repeat (20) @(posedge clk);
    rd("abort held", REF, r1);
    bus(1'b0, STA, 32'h0, 4'hF);
    check("abort idle", rdat, 32'h0);
    final_report();
  end
endmodule : power_mode_and_lp_osc_calibration_tb
